// ===== jbsp_pkg.sv
// jbsp_pkg: shared constants, types and instruction codes of the test access port
// assumes nothing beyond a systemverilog compiler
package jbsp_pkg;
  // =====================================================
  // register widths and identification field positions
  localparam int JBSP_IR_W = 10;
  localparam int JBSP_ID_W = 32;
  localparam int JBSP_UC_W = 32;
  localparam int JBSP_US_W = 16;
  localparam int JBSP_BSR_LEN = 288;
  localparam int JBSP_VER_POS = 28;
  localparam int JBSP_PART_POS = 12;
  localparam int JBSP_MFG_POS = 1;
  // =====================================================
  // values after reset and capture constants
  localparam logic [JBSP_IR_W-1:0] JBSP_IR_CAPTURE = 10'h001;
  localparam logic [JBSP_IR_W-1:0] JBSP_IR_RESET = 10'h059;
  // =====================================================
  // instruction codes (arbitrary encodings)
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_EXTEST = 10'h000;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_SAMPLE = 10'h055;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_IDENT = 10'h059;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_USER_DEFINED_CODE = 10'h007;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_USIG = 10'h079;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_PROG_EN = 10'h2cc;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_PROG_DONE = 10'h2f4;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_PROG_DIS = 10'h201;
  localparam logic [JBSP_IR_W-1:0] JBSP_OP_BYPASS = 10'h3ff;
  // =====================================================
  // data register selection
  typedef enum logic [2:0] {
    JBSP_SEL_BYPASS,
    JBSP_SEL_BSR,
    JBSP_SEL_IDENT,
    JBSP_SEL_UCODE,
    JBSP_SEL_USIG,
    JBSP_SEL_PROG
  } jbsp_sel_t;
endpackage

// ===== jbsp_tap_if.sv
// jbsp_tap_if: controller state strobes passed from the tap controller to the port logic
// assumes one test-clock domain on both sides
`timescale 1ns/1ps
interface jbsp_tap_if;
  logic test_reset;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;
  modport ctrl (output test_reset, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
  modport user (input test_reset, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
endinterface

// ===== jbsp_tap_ctrl.sv
// jbsp_tap_ctrl: sixteen-state test access controller advanced by mode select
// assumes tck_i is the test clock and tms is already synchronous to it
`timescale 1ns/1ps
module jbsp_tap_ctrl (
  // clock and reset
  input wire logic tck_i,
  input wire logic rst_n_i,
  // mode select
  input wire logic tms_i,
  // state strobes
  jbsp_tap_if.ctrl tap
);
  typedef enum logic [3:0] {
    RESET, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jbsp_tap_st_t;
  jbsp_tap_st_t st, next_st;

  // =====================================================
  // next state
  always_comb begin
    case (st)
      RESET: next_st = tms_i ? RESET : IDLE;
      IDLE: next_st = tms_i ? SEL_DR : IDLE;
      SEL_DR: next_st = tms_i ? SEL_IR : CAP_DR;
      CAP_DR: next_st = tms_i ? EX1_DR : SH_DR;
      SH_DR: next_st = tms_i ? EX1_DR : SH_DR;
      EX1_DR: next_st = tms_i ? UPD_DR : PAU_DR;
      PAU_DR: next_st = tms_i ? EX2_DR : PAU_DR;
      EX2_DR: next_st = tms_i ? UPD_DR : SH_DR;
      UPD_DR: next_st = tms_i ? SEL_DR : IDLE;
      SEL_IR: next_st = tms_i ? RESET : CAP_IR;
      CAP_IR: next_st = tms_i ? EX1_IR : SH_IR;
      SH_IR: next_st = tms_i ? EX1_IR : SH_IR;
      EX1_IR: next_st = tms_i ? UPD_IR : PAU_IR;
      PAU_IR: next_st = tms_i ? EX2_IR : PAU_IR;
      EX2_IR: next_st = tms_i ? UPD_IR : SH_IR;
      UPD_IR: next_st = tms_i ? SEL_DR : IDLE;
      default: next_st = RESET;
    endcase
  end

  // state register on rising test clock
  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= RESET;
    end else begin
      st <= next_st; // [RULE18]
    end
  end

  // state decodes
  assign tap.test_reset = (st == RESET);
  assign tap.cap_dr = (st == CAP_DR);
  assign tap.sh_dr = (st == SH_DR);
  assign tap.upd_dr = (st == UPD_DR);
  assign tap.cap_ir = (st == CAP_IR);
  assign tap.sh_ir = (st == SH_IR);
  assign tap.upd_ir = (st == UPD_IR);
endmodule

// ===== jbsp_port.sv
// jbsp_port: boundary scan test port with instruction, bypass, identification,
// user code, user signature and boundary registers, plus programming gating
// assumes tck_i comes from the external tester; clk_i is the core clock
// Operation
// [RULE1] instruction register is ten bits
// [RULE2] sample captures pins, core undisturbed
// [RULE3] sample preloads pattern for later output
// [RULE4] extest drives outputs, captures inputs
// [RULE5] bypass is one bit stage
// [RULE6] bypass shifts on test clock, core runs
// [RULE7] identification instruction selects id register
// [RULE8] id holds version, part, maker fields
// [RULE9] id least significant bit is one
// [RULE10] user code selects 32-bit register
// [RULE11] signature instruction shifts signature register; code does so only when HAS_USER_DEFINED_CODE is 0, else bypass
// [RULE12] signature register is sixteen bits
// [RULE13] boundary chain length fixed per size
// [RULE14] programming instructions accepted through port
// [RULE15] unused port pins serve as user pins
// [RULE16] programming tristates user pins with pullups
// [RULE17] outputs held off until programming complete
// [RULE18] sixteen-state controller stepped by mode select
// [RULE19] unknown instruction codes select bypass
// [RULE20] serial out on falling edge, else hiz
`timescale 1ns/1ps
module jbsp_port
  import jbsp_pkg::*;
#(
  parameter int NPIN = 96,
  parameter int BSR_LEN = jbsp_pkg::JBSP_BSR_LEN,
  parameter logic [3:0] ID_VERSION = 4'h0, // arbitrary value
  parameter logic [15:0] ID_PART = 16'h0000, // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h000, // arbitrary value
  parameter bit HAS_USER_DEFINED_CODE = 1'b1
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic tck_i,
  // test port pins
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // port enable strap: low frees the pins for user logic
  input wire logic port_en_i,
  // user code and signature contents
  input wire logic [jbsp_pkg::JBSP_UC_W-1:0] user_code_i,
  input wire logic [jbsp_pkg::JBSP_US_W-1:0] user_sig_i,
  // programming status from the array
  input wire logic prog_done_i,
  // core side pins
  input wire logic [NPIN-1:0] core_out_i,
  input wire logic [NPIN-1:0] core_oe_i,
  input wire logic [NPIN-1:0] pin_in_i,
  output logic [NPIN-1:0] pin_out_o,
  output logic [NPIN-1:0] pin_oe_o,
  output logic [NPIN-1:0] pin_pull_o,
  output logic [NPIN-1:0] core_in_o,
  output logic prog_mode_o
);
  import jbsp_pkg::*;

  jbsp_tap_if tap ();
  logic tst_rst_n;
  logic [1:0] tms_s, tdi_s;
  logic [JBSP_IR_W-1:0] ir_sh, next_ir_sh, ir, next_ir;
  logic byp, next_byp;
  logic [JBSP_ID_W-1:0] id_sh, next_id_sh;
  logic [JBSP_US_W-1:0] us_sh, next_us_sh;
  logic [BSR_LEN-1:0] bsr_sh, next_bsr_sh, bsr_up, next_bsr_up;
  logic prog, next_prog;
  logic tdo_bit, tdo_en;
  logic [JBSP_ID_W-1:0] id_word;
  jbsp_sel_t sel;
  logic [1:0] pm_s, pd_s;
  logic ext_on, ext_s1, ext_s2;
  logic [3*NPIN-1:0] pin_cap;
  logic pe_arst_n;
  logic [1:0] pe_s;
  logic upd_tg, next_upd_tg;
  logic [2:0] upd_s;
  logic [BSR_LEN-1:0] pat;

  // =====================================================
  // test pins pass two flops in the test clock domain
  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tms_s <= 2'h3;
      tdi_s <= 2'h0;
    end else begin
      tms_s <= {tms_s[0], tms_i};
      tdi_s <= {tdi_s[0], tdi_i};
    end
  end

  // port disabled holds controller in reset, pins go to user logic
  assign pe_arst_n = arst_n_i & port_en_i;

  // the strap resets at once but releases only after two test clocks,
  // so the test logic never leaves reset close to a test clock edge
  always_ff @(posedge tck_i or negedge pe_arst_n) begin
    if (!pe_arst_n) begin
      pe_s <= 2'h0;
    end else begin
      pe_s <= {pe_s[0], 1'b1};
    end
  end
  assign tst_rst_n = pe_s[1]; // [RULE15]

  jbsp_tap_ctrl u_ctrl (
    .tck_i(tck_i),
    .rst_n_i(tst_rst_n),
    .tms_i(tms_s[1]),
    .tap(tap)
  );

  // =====================================================
  // identification word, fields msb first, lsb forced one
  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // [RULE8] [RULE9]

  // pin snapshot: enables on top, outputs in the middle, inputs at the bottom
  assign pin_cap = {core_oe_i, core_out_i, pin_in_i};

  // instruction decode, unknown codes fall back to bypass
  always_comb begin
    case (ir)
      JBSP_OP_EXTEST, JBSP_OP_SAMPLE: sel = JBSP_SEL_BSR;
      JBSP_OP_IDENT: sel = JBSP_SEL_IDENT; // [RULE7]
      JBSP_OP_USER_DEFINED_CODE: sel = HAS_USER_DEFINED_CODE ? JBSP_SEL_UCODE : JBSP_SEL_BYPASS; // [RULE10]
      JBSP_OP_USIG: sel = HAS_USER_DEFINED_CODE ? JBSP_SEL_BYPASS : JBSP_SEL_USIG; // [RULE11]
      JBSP_OP_PROG_EN, JBSP_OP_PROG_DONE, JBSP_OP_PROG_DIS: sel = JBSP_SEL_PROG; // [RULE14]
      default: sel = JBSP_SEL_BYPASS; // [RULE19]
    endcase
  end

  // =====================================================
  // shift, capture and update next values
  always_comb begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_byp = byp;
    next_id_sh = id_sh;
    next_us_sh = us_sh;
    next_bsr_sh = bsr_sh;
    next_bsr_up = bsr_up;
    next_prog = prog;
    next_upd_tg = upd_tg;
    if (tap.test_reset) begin
      next_ir = JBSP_IR_RESET;
      next_prog = 1'b0;
    end
    if (tap.cap_ir) begin
      next_ir_sh = JBSP_IR_CAPTURE;
    end else if (tap.sh_ir) begin
      next_ir_sh = {tdi_s[1], ir_sh[JBSP_IR_W-1:1]}; // [RULE1]
    end else if (tap.upd_ir) begin
      next_ir = ir_sh;
    end
    if (tap.cap_dr) begin
      next_byp = 1'b0;
      next_id_sh = (sel == JBSP_SEL_UCODE) ? user_code_i : id_word;
      next_us_sh = user_sig_i; // [RULE12]
      if (sel == JBSP_SEL_BSR) begin
        // sample pins without touching the core path
        next_bsr_sh = pin_cap[BSR_LEN-1:0]; // [RULE2] [RULE4]
      end
    end else if (tap.sh_dr) begin
      case (sel)
        JBSP_SEL_BSR: next_bsr_sh = {tdi_s[1], bsr_sh[BSR_LEN-1:1]}; // [RULE13]
        JBSP_SEL_IDENT, JBSP_SEL_UCODE: next_id_sh = {tdi_s[1], id_sh[JBSP_ID_W-1:1]};
        JBSP_SEL_USIG: next_us_sh = {tdi_s[1], us_sh[JBSP_US_W-1:1]};
        default: next_byp = tdi_s[1]; // [RULE5] [RULE6]
      endcase
    end else if (tap.upd_dr) begin
      if (sel == JBSP_SEL_BSR) begin
        next_bsr_up = bsr_sh; // [RULE3]
        next_upd_tg = ~upd_tg; // tells the core side a new pattern stands
      end
    end
    if (tap.upd_ir) begin
      if (ir_sh == JBSP_OP_PROG_EN) begin
        next_prog = 1'b1; // [RULE14]
      end else if (ir_sh == JBSP_OP_PROG_DIS) begin
        next_prog = 1'b0;
      end
    end
  end

  always_ff @(posedge tck_i or negedge tst_rst_n) begin
    if (!tst_rst_n) begin
      ir_sh <= '0;
      ir <= JBSP_IR_RESET;
      byp <= 1'b0;
      id_sh <= '0;
      us_sh <= '0;
      bsr_sh <= '0;
      bsr_up <= '0;
      prog <= 1'b0;
      upd_tg <= 1'b0;
    end else begin
      upd_tg <= next_upd_tg;
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      byp <= next_byp;
      id_sh <= next_id_sh;
      us_sh <= next_us_sh;
      bsr_sh <= next_bsr_sh;
      bsr_up <= next_bsr_up;
      prog <= next_prog;
    end
  end

  // =====================================================
  // serial output mux
  always_comb begin
    tdo_bit = byp;
    if (tap.sh_ir) begin
      tdo_bit = ir_sh[0];
    end else begin
      case (sel)
        JBSP_SEL_BSR: tdo_bit = bsr_sh[0];
        JBSP_SEL_IDENT, JBSP_SEL_UCODE: tdo_bit = id_sh[0];
        JBSP_SEL_USIG: tdo_bit = us_sh[0];
        default: tdo_bit = byp;
      endcase
    end
  end
  assign tdo_en = tap.sh_ir | tap.sh_dr;

  // serial output registered on falling test clock, off outside shift
  always_ff @(negedge tck_i or negedge tst_rst_n) begin
    if (!tst_rst_n) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o <= tdo_bit; // [RULE20]
      tdo_oe_o <= tdo_en; // [RULE20]
    end
  end

  // extest level set on update of the instruction
  always_ff @(posedge tck_i or negedge tst_rst_n) begin
    if (!tst_rst_n) begin
      ext_on <= 1'b0;
    end else begin
      ext_on <= (ir == JBSP_OP_EXTEST);
    end
  end

  // =====================================================
  // level crossings into the core clock domain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pm_s <= 2'h0;
      pd_s <= 2'h0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      pm_s <= {pm_s[0], prog};
      pd_s <= {pd_s[0], prog_done_i};
      ext_s1 <= ext_on;
      ext_s2 <= ext_s1;
    end
  end

  // =====================================================
  // pattern word crosses by a synchronised toggle; the update register
  // stays still for many core clocks after each update, so the copy is clean
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upd_s <= 3'h0;
      pat <= '0;
    end else begin
      upd_s <= {upd_s[1:0], upd_tg};
      if (upd_s[2] ^ upd_s[1]) begin
        pat <= bsr_up; // [RULE3]
      end
    end
  end

  // =====================================================
  // pin drivers: extest pattern, programming hiz with pullups, done gating
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_o <= '0;
      pin_oe_o <= '0;
      pin_pull_o <= '0;
      core_in_o <= '0;
      prog_mode_o <= 1'b0;
    end else begin
      prog_mode_o <= pm_s[1];
      core_in_o <= pin_in_i;
      if (pm_s[1]) begin
        pin_oe_o <= '0; // [RULE16]
        pin_pull_o <= '1; // [RULE16]
        pin_out_o <= '0;
      end else if (!pd_s[1]) begin
        pin_oe_o <= '0; // [RULE17]
        pin_pull_o <= '0;
        pin_out_o <= '0;
      end else if (ext_s2) begin
        pin_out_o <= pat[2*NPIN-1:NPIN]; // [RULE4]
        pin_oe_o <= pat[BSR_LEN-1 -: NPIN];
        pin_pull_o <= '0;
      end else begin
        pin_out_o <= core_out_i; // [RULE2] [RULE6]
        pin_oe_o <= core_oe_i;
        pin_pull_o <= '0;
      end
    end
  end
endmodule

// ===== jbsp_port_chk.sv
// jbsp_port_chk: timing relations at the pins of the test port
// assumes it is bound to jbsp_port; one reset serves both clocks
`timescale 1ns/1ps
module jbsp_port_chk #(
  parameter int NPIN = 96
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic tck_i,
  // test port
  input wire logic port_en_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  // pins and programming
  input wire logic prog_done_i,
  input wire logic prog_mode_o,
  input wire logic [NPIN-1:0] pin_in_i,
  input wire logic [NPIN-1:0] pin_oe_o,
  input wire logic [NPIN-1:0] pin_pull_o,
  input wire logic [NPIN-1:0] core_in_o
);
  logic tdo_r;
  logic oe_r;
  // =========================================
  // serial outputs as seen at the rising test clock
  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) {tdo_r, oe_r} <= 2'h0;
    else {tdo_r, oe_r} <= {tdo_o, tdo_oe_o};
  end
  // pins quiet for two cycles, well clear of reset
  sequence pins_settled;
    $past(arst_n_i, 2) && $stable(pin_in_i) ##1 $stable(pin_in_i);
  endsequence
  // =========================================
  // assertions
  chk_core_copy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pins_settled |-> core_in_o == pin_in_i) else $error("core input copy wrong");
  chk_prog_pins: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    prog_mode_o && $past(prog_mode_o) |-> pin_oe_o == '0 && &pin_pull_o) else $error("pins driven in programming");
  chk_pull_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    |pin_pull_o |-> prog_mode_o || $past(prog_mode_o)) else $error("pull-up outside programming");
  chk_done_fall: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(prog_done_i) |-> ##[1:3] pin_oe_o == '0) else $error("drive not dropped");
  chk_done_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !prog_done_i && !$past(prog_done_i) && !$past(prog_done_i, 2) && !$past(prog_done_i, 3) |-> pin_oe_o == '0)
    else $error("drive while undone");
  chk_prog_port: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(prog_mode_o) |-> port_en_i) else $error("programming without port");
  chk_tdo_edge: assert property (@(negedge tck_i) disable iff (!arst_n_i)
    tdo_o == tdo_r && tdo_oe_o == oe_r) else $error("serial out moved in high phase");
  chk_port_off: assert property (@(posedge tck_i) disable iff (!arst_n_i)
    !port_en_i && !$past(port_en_i) && !$past(port_en_i, 2) |-> !tdo_oe_o) else $error("port drives while off");
endmodule
bind jbsp_port jbsp_port_chk #(.NPIN(NPIN)) u_chk (.clk_i, .arst_n_i, .tck_i, .port_en_i, .tdo_o, .tdo_oe_o,
  .prog_done_i, .prog_mode_o, .pin_in_i, .pin_oe_o, .pin_pull_o, .core_in_o);

// ===== jbsp_tester.sv
// jbsp_tester: board tester that clocks the port and shifts frames
// assumes the port syncs mode select and data in by two test clocks
`timescale 1ns/1ps
module jbsp_tester (
  // test port pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  bit q[$];
  // =========================================
  // clock parked low outside frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one test clock, inputs set in the low phase, output taken at the rise
  task automatic step(input logic m, input logic d);
    tms_o = m;
    tdi_o = d;
    #62.5 tck_o = 1'b1;
    if (tdo_oe_i === 1'b1) q.push_back(tdo_i);
    #62.5 tck_o = 1'b0;
  endtask
  // idle to shift, n bits lsb first, back to idle, then flush the syncs
  task automatic scan(input bit ir, input int n, input logic [319:0] din, output logic [319:0] dout,
                      output int cnt);
    q.delete();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    if (ir) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i]);
    step(1'b1, 1'b0);
    repeat (4) step(1'b0, 1'b0);
    tdi_o = ~din[0];
    dout = '0;
    cnt = q.size();
    foreach (q[i]) dout[i] = q[i];
  endtask
endmodule

// ===== testbench.sv
// testbench: drives the port through the tester model, compares with a bench model
// assumes jbsp_pkg, the design, checker and tester are compiled before it
`timescale 1ns/1ps
module testbench;
  import jbsp_pkg::*;
  localparam int NP = 96;
  localparam logic [31:0] IDW = {4'h3, 16'h5a3c, 11'h2b1, 1'b1}; // arbitrary identity
  logic clk_i, arst_n_i, port_en, done, tck, tms, tdi, tdo, tdo_oe, prog;
  logic [31:0] ucode, rnd;
  logic [15:0] usig;
  logic [NP-1:0] c_out, c_oe, p_in, p_out, p_oe, p_pull;
  logic [319:0] din, dout;
  logic [9:0] ops [5];
  int miscompares, checks_done, cnt;
  // =========================================
  // design and tester
  jbsp_port #(.NPIN(NP), .ID_VERSION(IDW[31:28]), .ID_PART(IDW[27:12]), .ID_MAKER(IDW[11:1])) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .port_en_i(port_en), .user_code_i(ucode), .user_sig_i(usig), .prog_done_i(done),
    .core_out_i(c_out), .core_oe_i(c_oe), .pin_in_i(p_in), .pin_out_o(p_out), .pin_oe_o(p_oe),
    .pin_pull_o(p_pull), .core_in_o(), .prog_mode_o(prog));
  jbsp_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  // core clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // xorshift stream shifted into din
  task automatic roll();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    din = {din[287:0], rnd};
  endtask
  // compare and count
  task automatic check(input string nm, input logic [319:0] seen, input logic [319:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected stream: captured bits first, then the bits shifted in
  function automatic logic [319:0] model(input logic [319:0] cap, input int len, input logic [319:0] d);
    logic [319:0] r;
    r = '0;
    for (int i = 0; i < len + 8; i++) r[i] = (i < len) ? cap[i] : d[i - len];
    return r;
  endfunction
  // load an instruction
  task automatic ir(input logic [9:0] op);
    tester.scan(1'b1, 10, {310'h0, op}, dout, cnt);
    check("ir count", cnt, 10);
    check("ir capture", dout, JBSP_IR_CAPTURE);
  endtask
  // shift a data register eight bits past its length
  task automatic dr(input logic [319:0] cap, input int len);
    repeat (10) roll();
    tester.scan(1'b0, len + 8, din, dout, cnt);
    check("dr count", cnt, len + 8);
    check("dr data", dout, model(cap, len, din));
  endtask
  // verdict
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #3000000;
    miscompares++;
    tally_and_finish();
  end
  // =========================================
  // main sequence
  initial begin
    miscompares = 0;
    checks_done = 0;
    rnd = 32'h00017569;
    din = '0;
    repeat (10) roll();
    {c_out, c_oe, p_in} = din[287:0];
    ucode = rnd;
    usig = din[47:32];
    arst_n_i = 1'b0;
    port_en = 1'b1;
    done = 1'b1;
    ops = '{JBSP_OP_USER_DEFINED_CODE, JBSP_OP_BYPASS, 10'h123, JBSP_OP_USIG, JBSP_OP_IDENT};
    fork
      repeat (2) tester.step(1'b1, 1'b0);
    join_none
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    wait fork;
    dr(IDW, 32);
    for (int k = 0; k < 5; k++) begin
      ir(ops[k]);
      dr(k == 0 ? ucode : (k == 4 ? IDW : 32'h0), k % 4 == 0 ? 32 : 1);
    end
    ir(JBSP_OP_SAMPLE);
    dr({c_oe, c_out, p_in}, 288);
    check("sample pins", {p_out, p_oe}, {c_out, c_oe});
    ir(JBSP_OP_EXTEST);
    @(negedge clk_i);
    p_in = ~p_in;
    repeat (4) @(negedge clk_i);
    check("extest drive", {p_oe, p_out}, din[295:104]);
    tester.scan(1'b0, 288, din, dout, cnt);
    check("extest capture", dout[NP-1:0], p_in);
    ir(JBSP_OP_PROG_EN);
    repeat (4) @(negedge clk_i);
    check("prog pins", {prog, p_oe, p_pull}, {1'b1, {NP{1'b0}}, {NP{1'b1}}});
    ir(JBSP_OP_PROG_DONE);
    ir(JBSP_OP_PROG_DIS);
    repeat (4) @(negedge clk_i);
    check("core pins", {prog, p_pull, p_oe, p_out}, {1'b0, {NP{1'b0}}, c_oe, c_out});
    done = 1'b0;
    repeat (4) @(negedge clk_i);
    check("undone drive", p_oe, '0);
    done = 1'b1;
    @(negedge clk_i);
    port_en = 1'b0;
    tester.scan(1'b1, 10, din, dout, cnt);
    check("port off", cnt, 0);
    @(negedge clk_i);
    port_en = 1'b1;
    repeat (2) tester.step(1'b1, 1'b0);
    dr(IDW, 32);
    tally_and_finish();
  end
endmodule
